//--- logic/sal_alu.sv
// single-cycle logic, bit-field, shift and flag alu
`timescale 1ns/1ns
`default_nettype none
`include "sal_consts.svh"
module sal_alu
  import sal_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire sal_req_t i_req,
  output sal_res_t o_res,
  output logic [31:0] o_sr
);

  // the datapath is written for a 32-bit word only
  initial begin
    if (DATA_W != 32) begin
      $error("sal_alu supports only DATA_W of 32");
    end
  end

  logic [31:0] sr_q;
  logic [31:0] sr_d;
  sal_res_t res_q;
  sal_res_t res_d;

  wire flag_c = sr_q[`SAL_FLAG_C];
  wire flag_z = sr_q[`SAL_FLAG_Z];
  wire flag_n = sr_q[`SAL_FLAG_N];
  wire flag_v = sr_q[`SAL_FLAG_V];

  // condition evaluation against current flags
  function automatic logic cond_true(input logic [3:0] c, input logic cf,
      input logic zf, input logic nf, input logic vf);
    logic r;
    r = 1'b0;
    unique case (c)
      4'h0: r = zf;
      4'h1: r = ~zf;
      4'h2: r = cf;
      4'h3: r = ~cf;
      4'h4: r = nf;
      4'h5: r = ~nf;
      4'h6: r = nf ^ vf;
      4'h7: r = ~(nf ^ vf);
      4'h8: r = ~cf & ~zf;
      4'h9: r = cf | zf;
      4'hA: r = ~zf & ~(nf ^ vf);
      4'hB: r = zf | (nf ^ vf);
      4'hC: r = vf;
      4'hD: r = ~vf;
      4'hE: r = 1'b1;
      4'hF: r = 1'b0;
    endcase
    return r;
  endfunction : cond_true

  wire cond_ok = cond_true(i_req.cond, flag_c, flag_z, flag_n, flag_v);

  // operand shaping for shifts and shifted logic
  wire [4:0] sh_amt = i_req.shift_amount;
  wire [31:0] rs_shifted = i_req.shift_right ? (i_req.rs >> sh_amt)
                                             : (i_req.rs << sh_amt);
  wire [31:0] asr_val = $signed(i_req.rs) >>> sh_amt;
  wire [31:0] lsl_val = i_req.rs << sh_amt;
  wire [31:0] lsr_val = i_req.rs >> sh_amt;

  // bit-field masks from width and offset; width 0 yields empty field
  wire [31:0] field_mask = (32'hFFFF_FFFF >> (6'd32 - {1'b0, i_req.field_width}))
                           & {32{i_req.field_width != 5'h0}};
  wire [31:0] ins_val = (i_req.rd & ~(field_mask << i_req.field_offset))
                        | ((i_req.rs & field_mask) << i_req.field_offset);
  wire [31:0] ext_raw = (i_req.rs >> i_req.field_offset) & field_mask;
  wire [4:0] ext_top = i_req.field_width - 5'h1;
  wire ext_sign = ext_raw[ext_top] & (i_req.field_width != 5'h0);
  wire [31:0] exts_val = ext_raw | (~field_mask & {32{ext_sign}});

  wire [31:0] one_hot = 32'h0000_0001 << i_req.bit_index;

  // per-bit reverse and per-byte zero detect
  logic [31:0] brev_val;
  logic [3:0] byte_zero;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_rev
      assign brev_val[gi] = i_req.rd[31 - gi];
    end
    for (gi = 0; gi < 4; gi++) begin : g_bz
      assign byte_zero[gi] = (i_req.rd[gi*8 +: 8] == 8'h00);
    end
  endgenerate

  // leading zero count, 32 when source is zero
  logic [5:0] clz_val;
  always_comb begin
    clz_val = 6'd32;
    for (int k = 0; k < 32; k++) begin
      if (i_req.rs[k]) begin
        clz_val = 6'(31 - k);
      end
    end
  end

  wire [31:0] hi_imm = {i_req.imm[15:0], 16'h0000};
  wire [31:0] lo_imm = {16'h0000, i_req.imm[15:0]};
  wire [32:0] sub_full = {1'b0, i_req.rd} - {1'b0, i_req.imm};

  // result and flag selection
  always_comb begin
    logic [31:0] r;
    logic wr;
    logic nz_upd;
    logic [31:0] s;
    r = i_req.rd;
    wr = 1'b1;
    nz_upd = 1'b1;
    s = sr_q;
    unique case (i_req.op)
      SAL_NOP: begin
        wr = 1'b0;
        nz_upd = 1'b0;
      end
      SAL_COND_SUB: begin
        wr = cond_ok;
        nz_upd = 1'b0;
        if (cond_ok) begin
          r = sub_full[31:0];
          s[`SAL_FLAG_C] = sub_full[32];
          s[`SAL_FLAG_V] = (i_req.rd[31] ^ i_req.imm[31])
                           & (i_req.rd[31] ^ r[31]);
          s[`SAL_FLAG_N] = r[31];
          s[`SAL_FLAG_Z] = (r == 32'h0000_0000);
        end
      end
      SAL_TNBZ: begin
        wr = 1'b0;
        nz_upd = 1'b0;
        s[`SAL_FLAG_Z] = |byte_zero;
        s[`SAL_FLAG_N] = 1'b0;
      end
      SAL_AND: r = i_req.rd & rs_shifted;
      SAL_OR: r = i_req.rd | rs_shifted;
      SAL_EOR: r = i_req.rd ^ rs_shifted;
      SAL_ANDN: r = i_req.rd & ~i_req.rs;
      SAL_COM: r = ~i_req.rd;
      SAL_ANDH: begin
        r = i_req.rd & (hi_imm | (i_req.clear_other_half_option
             ? 32'h0000_0000 : 32'h0000_FFFF));
      end
      SAL_ANDL: begin
        r = i_req.rd & (lo_imm | (i_req.clear_other_half_option
             ? 32'h0000_0000 : 32'hFFFF_0000));
      end
      SAL_ORH: r = i_req.rd | hi_imm;
      SAL_ORL: r = i_req.rd | lo_imm;
      SAL_EORH: r = i_req.rd ^ hi_imm;
      SAL_EORL: r = i_req.rd ^ lo_imm;
      SAL_TST: begin
        wr = 1'b0;
        r = i_req.rd & i_req.rs;
      end
      SAL_BFINS: r = ins_val;
      SAL_BFEXTS: r = exts_val;
      SAL_BFEXTU: r = ext_raw;
      SAL_BLD: begin
        wr = 1'b0;
        nz_upd = 1'b0;
        s[`SAL_FLAG_C] = i_req.rd[i_req.bit_index];
        s[`SAL_FLAG_Z] = i_req.rd[i_req.bit_index];
      end
      SAL_BST: begin
        nz_upd = 1'b0;
        r = flag_c ? (i_req.rd | one_hot) : (i_req.rd & ~one_hot);
      end
      SAL_BREV: r = brev_val;
      SAL_CASTS_B: r = {{24{i_req.rd[7]}}, i_req.rd[7:0]};
      SAL_CASTS_H: r = {{16{i_req.rd[15]}}, i_req.rd[15:0]};
      SAL_CASTU_B: r = {24'h000000, i_req.rd[7:0]};
      SAL_CASTU_H: r = {16'h0000, i_req.rd[15:0]};
      SAL_CBR: r = i_req.rd & ~one_hot;
      SAL_SBR: r = i_req.rd | one_hot;
      SAL_CLZ: begin
        r = {26'h0000000, clz_val};
        s[`SAL_FLAG_C] = (i_req.rs == 32'h0000_0000);
      end
      SAL_SWAP_B: r = {i_req.rd[7:0], i_req.rd[15:8],
                       i_req.rd[23:16], i_req.rd[31:24]};
      SAL_IN_HALF_BYTE_EXCHANGE: r = {i_req.rd[23:16], i_req.rd[31:24],
                        i_req.rd[7:0], i_req.rd[15:8]};
      SAL_SWAP_H: r = {i_req.rd[15:0], i_req.rd[31:16]};
      SAL_ASR: r = asr_val;
      SAL_LSL: r = lsl_val;
      SAL_LSR: r = lsr_val;
      SAL_ROL: begin
        r = {i_req.rd[30:0], flag_c};
        s[`SAL_FLAG_C] = i_req.rd[31];
      end
      SAL_ROR: begin
        r = {flag_c, i_req.rd[31:1]};
        s[`SAL_FLAG_C] = i_req.rd[0];
      end
      SAL_MOV: begin
        nz_upd = 1'b0;
        r = i_req.rs;
      end
      SAL_COND_MOV: begin
        nz_upd = 1'b0;
        wr = cond_ok;
        r = i_req.rs;
      end
      SAL_CSRF: begin
        wr = 1'b0;
        nz_upd = 1'b0;
        s = sr_q & ~one_hot;
      end
      SAL_SSRF: begin
        wr = 1'b0;
        nz_upd = 1'b0;
        s = sr_q | one_hot;
      end
      SAL_CSRFCZ: begin
        wr = 1'b0;
        nz_upd = 1'b0;
        s[`SAL_FLAG_C] = sr_q[i_req.bit_index];
        s[`SAL_FLAG_Z] = sr_q[i_req.bit_index];
      end
      SAL_COND_BOOL: begin
        nz_upd = 1'b0;
        r = {31'h0000_0000, cond_ok};
      end
      default: begin
        wr = 1'b0;
        nz_upd = 1'b0;
      end
    endcase
    // logic ops report zero and sign of what they computed
    if (nz_upd) begin
      s[`SAL_FLAG_Z] = (r == 32'h0000_0000);
      s[`SAL_FLAG_N] = r[31];
    end
    if (!i_req.valid) begin
      wr = 1'b0;
      s = sr_q;
    end
    res_d.valid = i_req.valid;
    res_d.wr_en = wr;
    res_d.data = r;
    sr_d = s;
  end

  // single register stage: result and flags one cycle after issue
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      res_q <= '{valid: 1'b0, wr_en: 1'b0, data: `SAL_RESULT_RESET};
      sr_q <= `SAL_SR_RESET;
    end else begin
      res_q <= res_d;
      sr_q <= sr_d;
    end
  end

  assign o_res = res_q;
  assign o_sr = sr_q;

  // checks next to the datapath
  sequence s_issue_cond_mov;
    i_req.valid && i_req.op == SAL_COND_MOV;
  endsequence

  a_result_latency_one: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) i_req.valid |=> o_res.valid)
    else $error("result not valid one cycle after issue");
  a_swap_full_word: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (i_req.valid && i_req.op == SAL_SWAP_B)
    |=> o_res.data == {$past(i_req.rd[7:0]), $past(i_req.rd[15:8]),
        $past(i_req.rd[23:16]), $past(i_req.rd[31:24])})
    else $error("byte swap result wrong");
  a_tst_no_write: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (i_req.valid && i_req.op == SAL_TST)
    |=> !o_res.wr_en && o_sr[`SAL_FLAG_Z]
        == ($past(i_req.rd & i_req.rs) == 32'h0))
    else $error("register test wrote back or bad zero flag");
  a_cond_mov_gate: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) s_issue_cond_mov ##0 !cond_ok
    |=> !o_res.wr_en)
    else $error("conditional copy wrote on false condition");
  a_cast_sign_ext: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (i_req.valid && i_req.op == SAL_CASTS_B)
    |=> o_res.data[31:8] == {24{$past(i_req.rd[7])}})
    else $error("signed byte cast did not sign-extend");
  a_rol_carry_in: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (i_req.valid && i_req.op == SAL_ROL)
    |=> o_res.data[0] == $past(flag_c)
        && o_sr[`SAL_FLAG_C] == $past(i_req.rd[31]))
    else $error("rotate left through carry wrong");
  a_ssrf_one_bit: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (i_req.valid && i_req.op == SAL_SSRF)
    |=> o_sr == ($past(sr_q) | $past(one_hot)))
    else $error("status set touched other bits");
  a_csrf_one_bit: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (i_req.valid && i_req.op == SAL_CSRF)
    |=> o_sr == ($past(sr_q) & ~$past(one_hot)))
    else $error("status clear touched other bits");
  a_cbr_one_bit: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (i_req.valid && i_req.op == SAL_CBR)
    |=> o_res.data == ($past(i_req.rd) & ~$past(one_hot)))
    else $error("bit clear touched other bits");
  a_bool_value: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (i_req.valid && i_req.op == SAL_COND_BOOL)
    |=> o_res.data == {31'h0, $past(cond_ok)})
    else $error("condition to boolean value wrong");
  a_bfins_keep: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (i_req.valid && i_req.op == SAL_BFINS)
    |=> (o_res.data & ~($past(field_mask) << $past(i_req.field_offset)))
        == ($past(i_req.rd)
            & ~($past(field_mask) << $past(i_req.field_offset))))
    else $error("field insert disturbed other bits");

endmodule : sal_alu
`default_nettype wire

//--- logic/sal_consts.svh
// timing and field constants for the single-cycle logic/bit-field alu
`ifndef SAL_CONSTS_SVH
`define SAL_CONSTS_SVH
`define SAL_LATENCY_CYC 1
`define SAL_FLAG_C 0
`define SAL_FLAG_Z 1
`define SAL_FLAG_N 2
`define SAL_FLAG_V 3
`define SAL_SR_RESET 32'h0000_0000
`define SAL_RESULT_RESET 32'h0000_0000
`endif

//--- logic/sal_pkg.sv
// types for the single-cycle logic/bit-field alu
package sal_pkg;
  typedef enum logic [5:0] {
    SAL_NOP, SAL_COND_SUB, SAL_TNBZ, SAL_AND, SAL_ANDN, SAL_OR, SAL_EOR,
    SAL_COM, SAL_ANDH, SAL_ANDL, SAL_ORH, SAL_ORL, SAL_EORH, SAL_EORL,
    SAL_TST, SAL_BFINS, SAL_BFEXTS, SAL_BFEXTU, SAL_BLD, SAL_BST, SAL_BREV,
    SAL_CASTS_B, SAL_CASTS_H, SAL_CASTU_B, SAL_CASTU_H, SAL_CBR, SAL_SBR,
    SAL_CLZ, SAL_SWAP_B, SAL_IN_HALF_BYTE_EXCHANGE, SAL_SWAP_H, SAL_ASR, SAL_LSL, SAL_LSR,
    SAL_ROL, SAL_ROR, SAL_MOV, SAL_COND_MOV, SAL_CSRF, SAL_CSRFCZ, SAL_SSRF,
    SAL_COND_BOOL
  } sal_op_t;

  // one issued instruction with its operands
  typedef struct packed {
    logic valid;
    sal_op_t op;
    logic [31:0] rd;
    logic [31:0] rs;
    logic [31:0] imm;
    logic [4:0] shift_amount;
    logic shift_right;
    logic [4:0] field_offset;
    logic [4:0] field_width;
    logic [4:0] bit_index;
    logic [3:0] cond;
    logic clear_other_half_option;
  } sal_req_t;

  // one result with its write enable
  typedef struct packed {
    logic valid;
    logic wr_en;
    logic [31:0] data;
  } sal_res_t;
endpackage : sal_pkg

//--- verif/sal_alu_tb.sv
// self-checking bench for the single-cycle logic and bit-field alu
`timescale 1ns/1ns
`default_nettype none
module sal_alu_tb;
  import sal_pkg::*;
  // w: 0 no write, 1 write, 2 destination value only, 3 unchecked
  typedef struct packed {
    logic v;
    logic [1:0] w;
    logic [31:0] d;
    logic [31:0] rd;
    logic [31:0] sr;
    logic [31:0] m;
  } sal_exp_t;
  logic i_ref_clk, i_rstn, fwd, lastw;
  sal_req_t cmd, req, r;
  sal_res_t o_res;
  logic [31:0] o_sr, seed, msr, km, last;
  sal_exp_t cur, pend;
  int errors, compares, cyc;

  sal_alu dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_req(req),
    .o_res(o_res), .o_sr(o_sr));
  sal_core_model fwd_path (.i_fwd(fwd), .i_cmd(cmd), .i_res(o_res),
    .o_req(req));

  // clock and hang guard
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // f is {v, n, z, c}
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    case (c)
      4'h0: return f[1];
      4'h1: return !f[1];
      4'h2: return f[0];
      4'h3: return !f[0];
      4'h4: return f[2];
      4'h5: return !f[2];
      4'h6: return f[2] != f[3];
      4'h7: return f[2] == f[3];
      4'h8: return !f[0] && !f[1];
      4'h9: return f[0] || f[1];
      4'hA: return !f[1] && f[2] == f[3];
      4'hB: return f[1] || f[2] != f[3];
      4'hC: return f[3];
      4'hD: return !f[3];
      4'hE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : cond_ok

  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // reference behaviour; flags not modelled are masked out of km
  task automatic model(input sal_req_t q);
    logic [31:0] a, b, y, fm, u;
    logic ok, t;
    a = q.rd;
    b = q.rs;
    ok = cond_ok(q.cond, msr[3:0]);
    y = q.shift_right ? b >> q.shift_amount : b << q.shift_amount;
    fm = (32'h1 << q.field_width) - 32'h1;
    u = (b >> q.field_offset) & fm;
    t = msr[q.bit_index];
    cur = '{1'b1, 2'd1, a, a, 32'h0, 32'h0};
    if (!(q.op inside {SAL_COND_MOV, SAL_COND_BOOL, SAL_CSRF, SAL_SSRF,
      SAL_CSRFCZ, SAL_BST, SAL_COND_SUB})) km[3:0] = 4'h0;
    case (q.op)
      SAL_COND_SUB: begin
        cur.w = 2'd2;
        if (ok) begin
          {t, cur.d} = {1'b0, a} - {1'b0, q.imm};
          msr[3:0] = {(a[31] ^ q.imm[31]) & (a[31] ^ cur.d[31]),
            cur.d[31], cur.d == 32'h0, t};
          km[3:0] = 4'hF;
        end
      end
      SAL_TNBZ: begin
        cur.w = 2'd2;
        msr[1] = a[31:24] == 8'h0 || a[23:16] == 8'h0 || a[15:8] == 8'h0
          || a[7:0] == 8'h0;
        msr[2] = 1'b0;
        km[2:1] = 2'h3;
      end
      SAL_AND: cur.d = a & y;
      SAL_OR: cur.d = a | y;
      SAL_EOR: cur.d = a ^ y;
      SAL_ANDN: cur.d = a & ~b;
      SAL_COM: cur.d = ~a;
      SAL_MOV: cur.d = b;
      SAL_ANDH: cur.d = {a[31:16] & q.imm[15:0],
        q.clear_other_half_option ? 16'h0 : a[15:0]};
      SAL_ANDL: cur.d = {q.clear_other_half_option ? 16'h0 : a[31:16],
        a[15:0] & q.imm[15:0]};
      SAL_ORH: cur.d = {a[31:16] | q.imm[15:0], a[15:0]};
      SAL_ORL: cur.d = {a[31:16], a[15:0] | q.imm[15:0]};
      SAL_EORH: cur.d = {a[31:16] ^ q.imm[15:0], a[15:0]};
      SAL_EORL: cur.d = {a[31:16], a[15:0] ^ q.imm[15:0]};
      SAL_TST: begin cur.w = 2'd0; cur.d = a & b; end
      SAL_BFINS: cur.d = (a & ~(fm << q.field_offset))
        | ((b << q.field_offset) & (fm << q.field_offset));
      SAL_BFEXTU: cur.d = u;
      SAL_BFEXTS: cur.d = u | ({32{q.field_width != 5'h0
        && u[q.field_width - 5'h1]}} & ~fm);
      SAL_BLD: begin cur.w = 2'd0; msr[1:0] = {2{a[q.bit_index]}}; km[1:0] = 2'h3; end
      SAL_BST: cur.d[q.bit_index] = msr[0];
      SAL_BREV: cur.d = {<<{a}};
      SAL_CASTS_B: cur.d = {{24{a[7]}}, a[7:0]};
      SAL_CASTS_H: cur.d = {{16{a[15]}}, a[15:0]};
      SAL_CASTU_B: cur.d = {24'h0, a[7:0]};
      SAL_CASTU_H: cur.d = {16'h0, a[15:0]};
      SAL_CBR: cur.d[q.bit_index] = 1'b0;
      SAL_SBR: cur.d[q.bit_index] = 1'b1;
      SAL_CLZ: begin
        cur.d = 32'h20;
        for (int i = 0; i < 32; i++) if (b[i]) cur.d = 32'(31 - i);
        msr[0] = b == 32'h0;
        km[0] = 1'b1;
      end
      SAL_SWAP_B: cur.d = {a[7:0], a[15:8], a[23:16], a[31:24]};
      SAL_IN_HALF_BYTE_EXCHANGE: cur.d = {a[23:16], a[31:24], a[7:0], a[15:8]};
      SAL_SWAP_H: cur.d = {a[15:0], a[31:16]};
      SAL_ASR: cur.d = 32'($signed(a) >>> q.shift_amount);
      SAL_LSL: cur.d = a << q.shift_amount;
      SAL_LSR: cur.d = a >> q.shift_amount;
      SAL_ROL: begin cur.d = {a[30:0], msr[0]}; msr[0] = a[31]; km[0] = 1'b1; end
      SAL_ROR: begin cur.d = {msr[0], a[31:1]}; msr[0] = a[0]; km[0] = 1'b1; end
      SAL_COND_MOV: begin cur.w = 2'd2; if (ok) cur.d = b; end
      SAL_COND_BOOL: cur.d = {31'h0, ok};
      SAL_CSRF: begin cur.w = 2'd0; msr[q.bit_index] = 1'b0; km[q.bit_index] = 1'b1; end
      SAL_SSRF: begin cur.w = 2'd0; msr[q.bit_index] = 1'b1; km[q.bit_index] = 1'b1; end
      SAL_CSRFCZ: begin
        cur.w = 2'd0;
        km[1:0] = {2{km[q.bit_index]}};
        msr[1:0] = {2{t}};
      end
      default: cur.w = 2'd3;
    endcase
    // ops other than the moves, bit store, condition-to-boolean and flag ops report zero and sign of their result
    if (!(q.op inside {SAL_COND_SUB, SAL_TNBZ, SAL_BLD, SAL_BST, SAL_MOV,
      SAL_COND_MOV, SAL_COND_BOOL, SAL_CSRF, SAL_SSRF, SAL_CSRFCZ})) begin
      msr[2:1] = {cur.d[31], cur.d == 32'h0};
      km[2:1] = 2'h3;
    end
    cur.sr = msr;
    cur.m = km;
  endtask : model

  // one op per call, driven just after the edge
  task automatic issue(input sal_req_t q, input logic f);
    @(posedge i_ref_clk);
    f = f && lastw;
    if (f) begin q.rd = last; q.rs = last; end
    if (q.valid) model(q);
    else cur = '{1'b0, 2'd3, 32'h0, 32'h0, msr, km};
    lastw = q.valid && cur.w == 2'd1;
    last = cur.d;
    cmd <= q;
    fwd <= f;
  endtask : issue

  task automatic set_flags;
    sal_req_t q;
    for (int i = 0; i < 4; i++) begin
      q = '0;
      q.valid = 1'b1;
      q.bit_index = 5'(i);
      q.op = xs() % 2 ? SAL_SSRF : SAL_CSRF;
      issue(q, 1'b0);
    end
  endtask : set_flags

  // result of each op is due one cycle after it is taken
  always @(negedge i_ref_clk) begin
    if (i_rstn) begin
      chk("valid", {31'h0, pend.v}, {31'h0, o_res.valid});
      if (pend.v && pend.w < 2'd2) chk("wr_en", {31'h0, pend.w[0]}, {31'h0, o_res.wr_en});
      if (pend.v && pend.w inside {2'd1, 2'd2}) chk("dest", pend.d, o_res.wr_en ? o_res.data : pend.rd);
      chk("flags", pend.sr & pend.m, o_sr & pend.m);
    end
    pend = cur;
  end

  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  initial begin
    i_rstn = 1'b0;
    fwd = 1'b0;
    cmd = '0;
    seed = 32'h20;
    msr = '0;
    km = '1;
    last = '0;
    lastw = 1'b0;
    cur = '0;
    pend = '0;
    repeat (5) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    @(negedge i_ref_clk);
    chk("sr_reset", 32'h0, o_sr);
    chk("res_reset", 32'h0, {30'h0, o_res.valid, o_res.wr_en} | o_res.data);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      r = '0;
      r.valid = 1'b1;
      r.op = SAL_COND_BOOL;
      r.cond = 4'(c);
      set_flags();
      issue(r, 1'b0);
    end
    $display("test conditions done");
    for (int k = 0; k < 400; k++) begin
      r = '0;
      r.valid = 1'b1;
      r.op = sal_op_t'(6'h1 + 6'(xs() % 41));
      r.rd = xs();
      r.rs = xs();
      r.imm = xs();
      {r.shift_amount, r.shift_right, r.field_offset, r.field_width,
        r.bit_index, r.cond, r.clear_other_half_option} = 26'(xs());
      if (int'(r.field_offset) + int'(r.field_width) > 32)
        r.field_offset = 5'(32 - int'(r.field_width));
      if (r.op inside {SAL_ASR, SAL_LSL, SAL_LSR}) r.rs = r.rd;
      if (r.op inside {SAL_COND_SUB, SAL_COND_MOV, SAL_COND_BOOL, SAL_ROL,
        SAL_ROR, SAL_BST}) set_flags();
      issue(r, xs() % 4 == 0);
      if (k % 50 == 49) issue('0, 1'b0);
    end
    repeat (3) issue('0, 1'b0);
    @(negedge i_ref_clk);
    $display("test random done");
    give_verdict();
  end
endmodule : sal_alu_tb
`default_nettype wire

//--- verif/sal_core_model.sv
// forwarding stage model feeding the alu from the bench
`timescale 1ns/1ns
`default_nettype none
module sal_core_model
  import sal_pkg::*;
(
  input wire logic i_fwd,
  input wire sal_req_t i_cmd,
  input wire sal_res_t i_res,
  output sal_req_t o_req
);
  // last result becomes both operands, as a back-to-back dependency would
  always_comb begin
    o_req = i_cmd;
    if (i_fwd && i_res.valid) begin
      o_req.rd = i_res.data;
      o_req.rs = i_res.data;
    end
  end
endmodule : sal_core_model
`default_nettype wire
